/* File: common/bpw_pkg.sv */
// Purpose: Shared constants and types for the prefetch window config block
// Assumes: Byte-addressed configuration space, 32-bit dword access with byte enables
// Notes:   Offsets are byte addresses within the bridge header

package bpw_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] BPW_OFF_PREF_BASE_LOW = 8'h24;
    localparam logic [7:0] BPW_OFF_PREF_LIMIT_LOW = 8'h26;
    localparam logic [7:0] BPW_OFF_BASE_UPPER = 8'h28;
    localparam logic [7:0] BPW_OFF_LIMIT_UPPER = 8'h2c;
    localparam logic [7:0] BPW_OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] BPW_OFF_INT_LINE = 8'h3c;
    localparam logic [7:0] BPW_OFF_INT_PIN = 8'h3d;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int BPW_ADDR_W = 40;
    localparam int BPW_WIN_LSB = 20;
    localparam int BPW_HIGH_W = 4;
    localparam logic [11:0] BPW_BASE_LOW_RST = 12'hfff;
    localparam logic [11:0] BPW_LIMIT_LOW_RST = 12'h000;
    localparam logic [3:0] BPW_ADDR64_CODE = 4'h1;
    localparam logic [31:0] BPW_BASE_UPPER_RST = 32'h0000000f;
    localparam logic [31:0] BPW_LIMIT_UPPER_RST = 32'h00000000;
    localparam logic [7:0] BPW_CAP_PTR_VAL = 8'h88;
    localparam logic [7:0] BPW_INT_LINE_RST = 8'h00;
    localparam logic [7:0] BPW_INT_PIN_VAL = 8'h01;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } bpw_cfg_req_s;

    typedef struct packed {
        logic valid;
        logic [BPW_ADDR_W-1:0] addr;
    } bpw_mem_req_s;

endpackage : bpw_pkg

/* File: core/bpw_window_decode.sv */
// Purpose: Inclusive 40-bit window compare for prefetchable routing
// Assumes: Base and limit arrive as 1 MB granular fields
// Notes:   Purely combinational; the hit is registered by the caller

`timescale 1ns/1ps
`default_nettype none

module bpw_window_decode (
    // Window bounds in 1 MB units
    input wire logic [19:0] base_mb,
    input wire logic [19:0] limit_mb,
    // Address under test
    input wire logic [bpw_pkg::BPW_ADDR_W-1:0] addr,
    // Result
    output logic hit
);
    import bpw_pkg::*;

    logic [BPW_ADDR_W-1:0] base_full;
    logic [BPW_ADDR_W-1:0] limit_full;

    always_comb begin
        base_full = {base_mb, {BPW_WIN_LSB{1'b0}}};
        limit_full = {limit_mb, {BPW_WIN_LSB{1'b1}}};
        hit = (addr >= base_full) && (addr <= limit_full);
    end

endmodule : bpw_window_decode

`default_nettype wire

/* File: core/bpw_config_regs.sv */
// Purpose: Prefetch window limit, upper base/limit, capability pointer and interrupt bytes
// Assumes: One configuration access per cycle; read data is returned one cycle later
// Notes:   Routing hit is registered one cycle after the memory request
//
// Functional notes
// - Route request inside inclusive 40-bit window
// - Limit low bits 15:4 writable, reset 000h
// - Limit low 20 address bits as ones
// - Base low 20 address bits as zeros
// - Limit low bits 3:0 read 1h
// - Upper base bits 3:0 writable, reset Fh
// - Upper limit bits 3:0 writable, reset 0h
// - Upper bits 31:4 plain storage, unused
// - Capability pointer reads constant 88h
// - Interrupt line writable, reset 00h, unused
// - Interrupt pin reads constant 01h
// - Base low bits 15:4 writable, reset FFFh

`timescale 1ns/1ps
`default_nettype none

module bpw_config_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Configuration access
    input wire bpw_pkg::bpw_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Processor memory request
    input wire bpw_pkg::bpw_mem_req_s mem_req,
    output logic route_valid,
    output logic route_to_graphics
);
    import bpw_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [11:0] base_low_q, base_low_d;
    logic [11:0] limit_low_q, limit_low_d;
    logic [31:0] base_upper_q, base_upper_d;
    logic [31:0] limit_upper_q, limit_upper_d;
    logic [7:0] int_line_q, int_line_d;
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic route_valid_q, route_valid_d;
    logic route_q, route_d;
    logic win_hit;

    logic wr;
    logic [7:0] dw_addr;
    logic [19:0] base_mb;
    logic [19:0] limit_mb;

    // Window bits above the upper nibble are not implemented and stay zero
    localparam int BPW_TOP_PAD_W = BPW_ADDR_W - BPW_WIN_LSB - BPW_HIGH_W - 12;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Merge one byte lane when its enable is set
    function automatic logic [7:0] lane(input logic en, input logic [7:0] old_v,
                                        input logic [7:0] new_v);
        lane = en ? new_v : old_v;
    endfunction : lane

    // Store a 12-bit window field; the nibble under it is a fixed code
    function automatic logic [11:0] field12(input logic [1:0] en,
                                            input logic [11:0] old_v,
                                            input logic [15:0] new_v);
        field12 = old_v;
        if (en[0]) begin
            field12[3:0] = new_v[7:4];
        end
        if (en[1]) begin
            field12[11:4] = new_v[15:8];
        end
    endfunction : field12

    // Read image of a low window register: field over its fixed code nibble
    function automatic logic [15:0] low_image(input logic [11:0] field);
        low_image = {field, BPW_ADDR64_CODE};
    endfunction : low_image

    // Write strobe for one dword of the header
    function automatic logic dword_wr(input logic w, input logic [7:0] a,
                                      input logic [7:0] off);
        dword_wr = w && (a == off);
    endfunction : dword_wr

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    always_comb begin
        wr = cfg_req.valid && cfg_req.write;
        dw_addr = {cfg_req.addr[7:2], 2'b00};
    end

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    always_comb begin
        base_low_d = base_low_q;
        limit_low_d = limit_low_q;
        base_upper_d = base_upper_q;
        limit_upper_d = limit_upper_q;
        int_line_d = int_line_q;
        if (dword_wr(wr, dw_addr, BPW_OFF_PREF_BASE_LOW)) begin
            base_low_d = field12(cfg_req.byte_en[1:0], base_low_q,
                                 cfg_req.wdata[15:0]);
            limit_low_d = field12(cfg_req.byte_en[3:2], limit_low_q,
                                  cfg_req.wdata[31:16]);
        end
        // Upper bits are stored as written; zeros are the caller's duty
        for (int b = 0; b < 4; b++) begin
            if (dword_wr(wr, dw_addr, BPW_OFF_BASE_UPPER)) begin
                base_upper_d[b*8 +: 8] = lane(cfg_req.byte_en[b], base_upper_q[b*8 +: 8],
                                              cfg_req.wdata[b*8 +: 8]);
            end
            if (dword_wr(wr, dw_addr, BPW_OFF_LIMIT_UPPER)) begin
                limit_upper_d[b*8 +: 8] = lane(cfg_req.byte_en[b], limit_upper_q[b*8 +: 8],
                                               cfg_req.wdata[b*8 +: 8]);
            end
        end
        if (dword_wr(wr, dw_addr, BPW_OFF_INT_LINE) && cfg_req.byte_en[0]) begin
            int_line_d = cfg_req.wdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rvalid_d = cfg_req.valid && !cfg_req.write;
        rdata_d = rdata_q;
        if (rvalid_d) begin
            unique case (dw_addr)
                BPW_OFF_PREF_BASE_LOW:
                    rdata_d = {low_image(limit_low_q), low_image(base_low_q)};
                BPW_OFF_BASE_UPPER: rdata_d = base_upper_q;
                BPW_OFF_LIMIT_UPPER: rdata_d = limit_upper_q;
                BPW_OFF_CAP_PTR: rdata_d = {24'h000000, BPW_CAP_PTR_VAL};
                BPW_OFF_INT_LINE: rdata_d = {16'h0000, BPW_INT_PIN_VAL, int_line_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Routing decode
    // ------------------------------------------------------------
    // Interrupt line and reserved upper bits never reach the compare.
    // Window bits 39:36 are fixed at zero, so a request with any of those
    // address bits set falls above the limit and is never routed.
    always_comb begin
        base_mb = {{BPW_TOP_PAD_W{1'b0}}, base_upper_q[BPW_HIGH_W-1:0], base_low_q};
        limit_mb = {{BPW_TOP_PAD_W{1'b0}}, limit_upper_q[BPW_HIGH_W-1:0], limit_low_q};
    end

    bpw_window_decode u_decode (
        .base_mb(base_mb),
        .limit_mb(limit_mb),
        .addr(mem_req.addr),
        .hit(win_hit)
    );

    always_comb begin
        route_valid_d = mem_req.valid;
        route_d = mem_req.valid && win_hit;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Configuration storage; a write is visible to a read one cycle later
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            base_low_q <= BPW_BASE_LOW_RST;
            limit_low_q <= BPW_LIMIT_LOW_RST;
            base_upper_q <= BPW_BASE_UPPER_RST;
            limit_upper_q <= BPW_LIMIT_UPPER_RST;
            int_line_q <= BPW_INT_LINE_RST;
        end else begin
            base_low_q <= base_low_d;
            limit_low_q <= limit_low_d;
            base_upper_q <= base_upper_d;
            limit_upper_q <= limit_upper_d;
            int_line_q <= int_line_d;
        end
    end

    // Read answer; the data holds between reads so a late sampler
    // still sees the last value
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Routing answer, judged on the bounds of the cycle the request arrives
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            route_valid_q <= 1'b0;
            route_q <= 1'b0;
        end else begin
            route_valid_q <= route_valid_d;
            route_q <= route_d;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_rvalid = rvalid_q;
    assign route_valid = route_valid_q;
    assign route_to_graphics = route_q;

endmodule : bpw_config_regs

`default_nettype wire

/* File: verif/bpw_config_regs_sva.sv */
// Purpose: Port checks for the prefetch window config block
// Assumes: One clock, active-low asynchronous reset
// Notes:   Read data is judged one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module bpw_config_regs_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Watched ports
    input wire bpw_pkg::bpw_cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire bpw_pkg::bpw_mem_req_s mem_req,
    input wire logic route_valid,
    input wire logic route_to_graphics
);
    import bpw_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_rd(logic [5:0] dw);
        cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == dw;
    endsequence
    sequence s_wr(logic [5:0] dw);
        cfg_req.valid && cfg_req.write && cfg_req.byte_en[0] && cfg_req.addr[7:2] == dw;
    endsequence
    chk_read_answer: assert property (cfg_req.valid && !cfg_req.write |=> cfg_rvalid)
        else $error("read not answered next cycle");
    chk_no_extra: assert property (!(cfg_req.valid && !cfg_req.write) |=> !cfg_rvalid)
        else $error("read valid without a read");
    chk_cap_value: assert property (s_rd(6'h0d) |=> cfg_rdata == 32'h00000088)
        else $error("capability pointer wrong");
    chk_pin_value: assert property (s_rd(6'h0f) |=> cfg_rdata[31:8] == 24'h000001)
        else $error("interrupt pin wrong");
    chk_low_codes: assert property (s_rd(6'h09) |=> cfg_rdata[19:16] == 4'h1 && cfg_rdata[3:0] == 4'h1)
        else $error("address support code wrong");
    chk_line_keep: assert property (s_wr(6'h0f) ##2 s_rd(6'h0f) |=>
        cfg_rdata[7:0] == $past(cfg_req.wdata[7:0], 3))
        else $error("interrupt line lost");
    chk_route_answer: assert property (mem_req.valid |=> route_valid)
        else $error("route not answered");
    chk_route_quiet: assert property (!mem_req.valid |=> !route_valid && !route_to_graphics)
        else $error("route without request");
    chk_high_outside: assert property (mem_req.valid && mem_req.addr[39:36] != 4'h0 |=>
        !route_to_graphics)
        else $error("address above 36 bits routed");
endmodule : bpw_config_regs_sva
bind bpw_config_regs bpw_config_regs_sva chk_u (.clock(clock), .reset_n(reset_n),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .mem_req(mem_req),
    .route_valid(route_valid), .route_to_graphics(route_to_graphics));
`default_nettype wire

/* File: verif/bpw_host_model.sv */
// Purpose: Processor side issuing memory requests
// Assumes: One request per cycle
// Notes:   Idle address is inverted so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module bpw_host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench command
    input wire logic go,
    input wire logic [39:0] addr,
    // Request out
    output var bpw_pkg::bpw_mem_req_s mem_req
);
    import bpw_pkg::*;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            mem_req <= '0;
        else
            mem_req <= go ? {1'b1, addr} : {1'b0, ~mem_req.addr};
    end
endmodule : bpw_host_model
`default_nettype wire

/* File: verif/bridge_prefetch_window_config_tb_top.sv */
// Purpose: Self-checking bench for the prefetch window config block
// Assumes: Reads answer one cycle after the request
// Notes:   Expected values come from a dword array model
`timescale 1ns/1ps
`default_nettype none
module bridge_prefetch_window_config_tb_top;
    import bpw_pkg::*;
    logic clock, reset_n, go, rv, rg, cfg_rvalid;
    logic [39:0] ga, b, l;
    logic [31:0] cfg_rdata, r, m, mdl[64];
    bpw_cfg_req_s cfg_req;
    bpw_mem_req_s mem_req;
    int n_mismatch, checks;
    bpw_config_regs dut_u (.clock(clock), .reset_n(reset_n), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .mem_req(mem_req),
        .route_valid(rv), .route_to_graphics(rg));
    bpw_host_model host_u (.clock(clock), .reset_n(reset_n), .go(go), .addr(ga),
        .mem_req(mem_req));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic acc(logic w, logic [7:0] a, logic [3:0] be, logic [31:0] d);
        @(posedge clock);
        cfg_req <= {1'b1, w, a, be, d};
        @(posedge clock);
        cfg_req.valid <= 1'b0;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        m &= (a[7:2] == 6'h09) ? 32'hfff0fff0 : (a[7:2] == 6'h0a || a[7:2] == 6'h0b) ?
            32'hffffffff : (a[7:2] == 6'h0f) ? 32'h000000ff : 32'h0;
        if (w)
            mdl[a[7:2]] = (mdl[a[7:2]] & ~m) | (d & m);
        #1;
        if (!w) begin
            chk("read valid", {31'h0, cfg_rvalid}, 32'h1);
            chk("read data", cfg_rdata, mdl[a[7:2]]);
        end
    endtask : acc
    task automatic mem(logic [39:0] a);
        @(posedge clock);
        go <= 1'b1;
        ga <= a;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
        chk("route", {30'h0, rv, rg}, {30'h0, 1'b1,
            a >= {mdl[10][3:0], mdl[9][15:4], 20'h0} &&
            a <= {mdl[11][3:0], mdl[9][31:20], 20'hfffff}});
    endtask : mem
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #150000;
        n_mismatch++;
        conclude();
    end
    initial begin
        reset_n = 1'b0;
        cfg_req = '0;
        go = 1'b0;
        ga = '0;
        r = 32'h99f764ae;
        mdl = '{default: 32'h0};
        mdl[9] = 32'h0001fff1;
        mdl[10] = 32'h0000000f;
        mdl[13] = 32'h00000088;
        mdl[15] = 32'h00000100;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 68; i += 4)
            acc(1'b0, 8'(i), 4'h0, 32'h0);
        mem(40'h0);
        $display("test reset values done");
        for (int k = 0; k < 40; k++) begin
            if (k < 34) begin
                r = lfsr(r);
                acc(1'b1, 8'h24, r[3:0], r);
                acc(1'b1, 8'h28, 4'hf, {30'h0, r[5:4]});
                acc(1'b1, 8'h2c, 4'hf, {28'h0, 1'b1, r[8:6]});
                acc(1'b0, 8'h24, 4'h0, 32'h0);
                b = {mdl[10][3:0], mdl[9][15:4], 20'h0};
                l = {mdl[11][3:0], mdl[9][31:20], 20'hfffff};
                mem(b);
                mem(b - 40'h1);
                mem(l);
                mem(l + 40'h1);
                mem({r[7:4], r, r[3:0]});
            end
        end
        $display("test window routing done");
        for (int k = 0; k < 40; k++) begin
            if (k < 4) begin
                ga = {8'h40, 8'h3c, 8'h34, 8'h24} >> (8 * k);
                acc(1'b1, ga[7:0], 4'hf, 32'hffffffff);
                acc(1'b0, ga[7:0], 4'h0, 32'h0);
            end
        end
        $display("test read-only and unmapped done");
        conclude();
    end
endmodule : bridge_prefetch_window_config_tb_top
`default_nettype wire
